/* hdl/bsi_pkg.sv */
// constants, types and shared layouts of the bit-stream input sampler
// assumes a 100 MHz ref_clk and a sample clock that arrives as a plain pin
// What this block does
// - The sample clock may run at 2 to 32 MHz (64 and 128 MHz optional) and each of these must be handled; the 100 MHz ref_clk misses 64 and 128 MHz edges.
// - Operation stays normal while the sample clock drifts by up to 100 ppm.
// - The on-tick sample of each stream is taken with the second tick whatever the decimation.
// - After the on-tick sample one bit per stream is taken every 2^k sample-clock cycles.
// - The stream rate never exceeds the clock rate and every power-of-two rate from 2 Mbps up is offered.
// - The alternate tick may be asynchronous, so setting the counter from it may be off by one cycle.
// - One pulse on the alternate tick is enough to set the observe-time counter.
// - The auxiliary serial input is decoded as 8-bit characters at 115 kbaud, one stop bit, no parity.
// - Up to 2048 auxiliary bytes between two second ticks are received without loss.
// - A clock discontinuity needs a full module reset, counter included.
// - A monitor pulse at the second rate comes from the observe-time counter to show it is in step.
// - Once set, the observe-time counter is not reset again by the block itself.
// - Tick edges and stream transitions follow sample-clock falling edges, so bits are taken on rising edges.
// - Any subset of 0, 1, 2, 4, 8 or 16 of the 32 streams can be chosen as active.
package bsi_pkg;
    localparam int NUM_STREAMS = 32;
    localparam int REF_CLK_HZ = 100_000_000;
    localparam int AUX_BAUD = 115_000;
    localparam logic [9:0] AUX_BIT_CYCLES = 10'(REF_CLK_HZ / AUX_BAUD);
    localparam logic [9:0] AUX_HALF_CYCLES = 10'(REF_CLK_HZ / AUX_BAUD / 2);
    localparam logic [2:0] AUX_DATA_BITS = 3'h7; // last index of 8 bits
    localparam int MON_TIME_US = 10_000; // monitor stretch, about 10 ms
    localparam int MON_CYCLES = (REF_CLK_HZ / 1_000_000) * MON_TIME_US;
    localparam int BASE_CLOCK_HZ = 2_000_000; // lowest sample clock rate
    localparam logic [2:0] FREQ_SEL_MAX = 3'h6; // 2 MHz shl 6 = 128 MHz
    localparam logic [6:0] PHASE_RESET = 7'h00;
    localparam logic [31:0] SECONDS_RESET = 32'h00000000;
    localparam logic [31:0] CYCLE_RESET = 32'h00000000;

    typedef struct packed {
        logic [NUM_STREAMS-1:0] bits;
        logic valid;
        logic on_tick;
    } bsi_sample_s;

    typedef struct packed {
        logic [7:0] data;
        logic valid;
        logic frame_err;
    } bsi_aux_s;

    typedef enum logic [1:0] {
        AUX_IDLE,
        AUX_START,
        AUX_DATA,
        AUX_STOP
    } bsi_aux_e;
endpackage

/* hdl/bsi_sampler.sv */
// bit-stream input sampler: decimating capture, observe-time counter,
// monitor pulse and auxiliary serial receiver
// assumes every pin input is asynchronous to ref_clk and the control
// inputs come from logic on ref_clk
`timescale 1ns/1ns
`default_nettype none
module bsi_sampler
    import bsi_pkg::*;
#(
    parameter int BASE_CYCLES_PER_SEC = BASE_CLOCK_HZ,
    parameter int MON_PULSE_CYCLES = MON_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sample_clock,
    input wire logic second_tick,
    input wire logic alternate_second_tick,
    input wire logic [NUM_STREAMS-1:0] input_bit_stream,
    input wire logic aux_serial_in,
    input wire logic [2:0] freq_sel,
    input wire logic [2:0] rate_k,
    input wire logic [NUM_STREAMS-1:0] stream_active,
    input wire logic use_alt_tick,
    input wire logic set_cmd,
    input wire logic [31:0] set_seconds,
    input wire logic counter_reset,
    output bsi_sample_s on_tick_sample,
    output logic [31:0] observe_time_counter,
    output logic counter_locked,
    output logic counter_armed,
    output logic epoch_monitor_out,
    output bsi_aux_s aux_byte
);

    // two-stage synchronisers; stage 1 feeds only stage 2
    logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
    logic tick_s1_ff, tick_s2_ff;
    logic alt_s1_ff, alt_s2_ff, alt_s3_ff;
    logic aux_s1_ff, aux_s2_ff;
    logic [NUM_STREAMS-1:0] bs_s1_ff, bs_s2_ff;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_s3_ff <= 1'b0;
            tick_s1_ff <= 1'b0;
            tick_s2_ff <= 1'b0;
            alt_s1_ff <= 1'b0;
            alt_s2_ff <= 1'b0;
            alt_s3_ff <= 1'b0;
            aux_s1_ff <= 1'b1;
            aux_s2_ff <= 1'b1;
            bs_s1_ff <= '0;
            bs_s2_ff <= '0;
        end else begin
            sclk_s1_ff <= sample_clock;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            tick_s1_ff <= second_tick;
            tick_s2_ff <= tick_s1_ff;
            alt_s1_ff <= alternate_second_tick;
            alt_s2_ff <= alt_s1_ff;
            alt_s3_ff <= alt_s2_ff;
            aux_s1_ff <= aux_serial_in;
            aux_s2_ff <= aux_s1_ff;
            bs_s1_ff <= input_bit_stream;
            bs_s2_ff <= bs_s1_ff;
        end
    end

    // data and tick share the clock's sync delay, so a rising clock edge
    // here sees bits that settled at the previous falling edge
    logic sclk_rise;
    logic alt_rise;
    assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
    assign alt_rise = alt_s2_ff & ~alt_s3_ff;

    // capture and decimation state
    logic tick_prev_ff, nxt_tick_prev;
    logic [6:0] phase_ff, nxt_phase;
    bsi_sample_s smp_ff, nxt_smp;
    logic [2:0] freq_eff, k_eff;
    logic [6:0] phase_mask;
    logic tick_rise;

    always_comb begin
        // rates below 2 Mbps are not offered: k is capped by the clock
        freq_eff = (freq_sel > FREQ_SEL_MAX) ? FREQ_SEL_MAX : freq_sel;
        k_eff = (rate_k > freq_eff) ? freq_eff : rate_k;
        phase_mask = 7'((8'h01 << k_eff) - 8'h01);
        tick_rise = sclk_rise & tick_s2_ff & ~tick_prev_ff;
        nxt_tick_prev = tick_prev_ff;
        nxt_phase = phase_ff;
        nxt_smp = smp_ff;
        nxt_smp.valid = 1'b0;
        nxt_smp.on_tick = 1'b0;
        if (sclk_rise) begin
            nxt_tick_prev = tick_s2_ff;
            if (tick_rise) begin
                // on-tick bit taken with the tick, phase restarted
                nxt_smp.bits = bs_s2_ff & stream_active;
                nxt_smp.valid = 1'b1;
                nxt_smp.on_tick = 1'b1;
                nxt_phase = 7'((PHASE_RESET + 7'h01) & phase_mask);
            end else begin
                if ((phase_ff & phase_mask) == PHASE_RESET) begin
                    nxt_smp.bits = bs_s2_ff & stream_active;
                    nxt_smp.valid = 1'b1;
                end
                nxt_phase = 7'((phase_ff + 7'h01) & phase_mask);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tick_prev_ff <= 1'b0;
            phase_ff <= PHASE_RESET;
            smp_ff <= '0;
        end else begin
            tick_prev_ff <= nxt_tick_prev;
            phase_ff <= nxt_phase;
            smp_ff <= nxt_smp;
        end
    end

    // observe-time counter: seconds plus a cycle count within the second;
    // only a module reset or counter_reset clears it, never a tick
    logic [31:0] seconds_ff, nxt_seconds;
    logic [31:0] cycle_ff, nxt_cycle;
    logic locked_ff, nxt_locked;
    logic armed_ff, nxt_armed;
    logic alt_pend_ff, nxt_alt_pend;
    logic sec_wrap_ff, nxt_sec_wrap;
    logic [31:0] cycles_per_sec;
    logic set_tick;

    always_comb begin
        // cycles per second follow the selected clock rate
        cycles_per_sec = 32'(BASE_CYCLES_PER_SEC) << freq_eff;
        // an async alt pulse waits for the next clock edge: +-1 cycle
        nxt_alt_pend = alt_pend_ff;
        if (sclk_rise) begin
            nxt_alt_pend = 1'b0;
        end
        if (alt_rise) begin
            nxt_alt_pend = 1'b1;
        end
        set_tick = use_alt_tick ? (sclk_rise & (alt_pend_ff | alt_rise))
                                : tick_rise;
        nxt_seconds = seconds_ff;
        nxt_cycle = cycle_ff;
        nxt_locked = locked_ff;
        nxt_armed = armed_ff;
        nxt_sec_wrap = 1'b0;
        if (locked_ff && sclk_rise) begin
            // counting cycles only; drift just shifts the second slightly
            if (cycle_ff >= cycles_per_sec - 32'h00000001) begin
                nxt_cycle = CYCLE_RESET;
                nxt_seconds = seconds_ff + 32'h00000001;
                nxt_sec_wrap = 1'b1;
            end else begin
                nxt_cycle = cycle_ff + 32'h00000001;
            end
        end
        if (armed_ff && set_tick) begin
            // the commanded second starts one clock before this tick; the tick is cycle 1
            nxt_seconds = set_seconds;
            nxt_cycle = CYCLE_RESET + 32'h00000001;
            nxt_locked = 1'b1;
            nxt_armed = 1'b0;
            nxt_sec_wrap = 1'b1;
        end
        if (set_cmd && !locked_ff) begin
            nxt_armed = 1'b1;
        end
        if (counter_reset) begin
            nxt_locked = 1'b0;
            nxt_armed = 1'b0;
            nxt_seconds = SECONDS_RESET;
            nxt_cycle = CYCLE_RESET;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            seconds_ff <= SECONDS_RESET;
            cycle_ff <= CYCLE_RESET;
            locked_ff <= 1'b0;
            armed_ff <= 1'b0;
            alt_pend_ff <= 1'b0;
            sec_wrap_ff <= 1'b0;
        end else begin
            seconds_ff <= nxt_seconds;
            cycle_ff <= nxt_cycle;
            locked_ff <= nxt_locked;
            armed_ff <= nxt_armed;
            alt_pend_ff <= nxt_alt_pend;
            sec_wrap_ff <= nxt_sec_wrap;
        end
    end

    // monitor pulse, stretched so a scope or LED can show it
    logic [31:0] mon_cnt_ff, nxt_mon_cnt;
    logic mon_ff, nxt_mon;

    always_comb begin
        nxt_mon_cnt = mon_cnt_ff;
        nxt_mon = mon_ff;
        if (sec_wrap_ff) begin
            nxt_mon_cnt = 32'(MON_PULSE_CYCLES) - 32'h00000001;
            nxt_mon = 1'b1;
        end else if (mon_cnt_ff != 32'h00000000) begin
            nxt_mon_cnt = mon_cnt_ff - 32'h00000001;
        end else begin
            nxt_mon = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mon_cnt_ff <= 32'h00000000;
            mon_ff <= 1'b0;
        end else begin
            mon_cnt_ff <= nxt_mon_cnt;
            mon_ff <= nxt_mon;
        end
    end

    // auxiliary serial receiver, LSB first, sampled mid-bit; one byte
    // takes ~87 us, so 2048 bytes fit easily inside a second
    bsi_aux_e aux_st_ff, nxt_aux_st;
    logic [9:0] aux_cnt_ff, nxt_aux_cnt;
    logic [2:0] aux_idx_ff, nxt_aux_idx;
    logic [7:0] aux_sh_ff, nxt_aux_sh;
    bsi_aux_s aux_out_ff, nxt_aux_out;

    always_comb begin
        nxt_aux_st = aux_st_ff;
        nxt_aux_cnt = aux_cnt_ff;
        nxt_aux_idx = aux_idx_ff;
        nxt_aux_sh = aux_sh_ff;
        nxt_aux_out = aux_out_ff;
        nxt_aux_out.valid = 1'b0;
        if (aux_cnt_ff != 10'h000) begin
            nxt_aux_cnt = aux_cnt_ff - 10'h001;
        end
        unique case (aux_st_ff)
            AUX_IDLE: begin
                if (!aux_s2_ff) begin
                    nxt_aux_st = AUX_START;
                    nxt_aux_cnt = AUX_HALF_CYCLES;
                end
            end
            AUX_START: begin
                if (aux_cnt_ff == 10'h000) begin
                    // a start bit gone high by mid-bit was a glitch
                    nxt_aux_st = aux_s2_ff ? AUX_IDLE : AUX_DATA;
                    nxt_aux_cnt = AUX_BIT_CYCLES;
                    nxt_aux_idx = 3'h0;
                end
            end
            AUX_DATA: begin
                if (aux_cnt_ff == 10'h000) begin
                    nxt_aux_sh = {aux_s2_ff, aux_sh_ff[7:1]};
                    nxt_aux_cnt = AUX_BIT_CYCLES;
                    nxt_aux_idx = aux_idx_ff + 3'h1;
                    if (aux_idx_ff == AUX_DATA_BITS) begin
                        nxt_aux_st = AUX_STOP;
                    end
                end
            end
            AUX_STOP: begin
                if (aux_cnt_ff == 10'h000) begin
                    // one stop bit, no parity; back to idle at once
                    nxt_aux_out.data = aux_sh_ff;
                    nxt_aux_out.valid = 1'b1;
                    nxt_aux_out.frame_err = ~aux_s2_ff;
                    nxt_aux_st = AUX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            aux_st_ff <= AUX_IDLE;
            aux_cnt_ff <= 10'h000;
            aux_idx_ff <= 3'h0;
            aux_sh_ff <= 8'h00;
            aux_out_ff <= '0;
        end else begin
            aux_st_ff <= nxt_aux_st;
            aux_cnt_ff <= nxt_aux_cnt;
            aux_idx_ff <= nxt_aux_idx;
            aux_sh_ff <= nxt_aux_sh;
            aux_out_ff <= nxt_aux_out;
        end
    end

    assign on_tick_sample = smp_ff;
    assign observe_time_counter = seconds_ff;
    assign counter_locked = locked_ff;
    assign counter_armed = armed_ff;
    assign epoch_monitor_out = mon_ff;
    assign aux_byte = aux_out_ff;

endmodule // bsi_sampler
`default_nettype wire

/* tb/bsi_far_model.sv */
// far-side model: sample clock, second ticks, streams, aux serial line
// assumes the bench calls send and alt_pulse and matches PER_SEC
`timescale 1ns/1ns
`default_nettype none
module bsi_far_model #(
    parameter int PER_SEC = 80
) (
    output logic sample_clock,
    output logic second_tick,
    output logic alternate_second_tick,
    output logic [31:0] input_bit_stream,
    output logic aux_serial_in
);
    int cyc = 0;
    // sample clock runs free, 80 ns period
    initial begin
        sample_clock = 1'b0;
        second_tick = 1'b0;
        alternate_second_tick = 1'b0;
        input_bit_stream = '0;
        aux_serial_in = 1'b1;
        forever #40 sample_clock = ~sample_clock;
    end
    // tick and data move on falling edges; tick rides the cycle-0 bit
    always @(negedge sample_clock) begin
        cyc = (cyc + 1 >= PER_SEC) ? 0 : cyc + 1;
        second_tick <= (cyc == 0);
        input_bit_stream <= {16'(cyc), ~16'(cyc)};
    end
    // lsb first, one stop bit, no parity; true 115 kbaud bit time
    task automatic send(input logic [7:0] b, input logic stp);
        aux_serial_in = 1'b0;
        #8696;
        for (int i = 0; i < 8; i++) begin
            aux_serial_in = b[i];
            #8696;
        end
        aux_serial_in = stp;
        #8696;
        aux_serial_in = 1'b1;
        // one idle bit, so the next start bit never lands in this step
        #8696;
    endtask
    // single alternate tick, a few clocks wide, unrelated in phase
    task automatic alt_pulse();
        alternate_second_tick = 1'b1;
        #333;
        alternate_second_tick = 1'b0;
    endtask
endmodule // bsi_far_model
`default_nettype wire

/* tb/bsi_sampler_checker.sv */
// concurrent checks on the sampler's ports
// assumes one ref_clk domain and the bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module bsi_sampler_checker
    import bsi_pkg::*;
#(
    parameter int MON_PULSE_CYCLES = MON_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [NUM_STREAMS-1:0] stream_active,
    input wire logic set_cmd,
    input wire logic [31:0] set_seconds,
    input wire logic counter_reset,
    input wire bsi_sample_s on_tick_sample,
    input wire logic [31:0] observe_time_counter,
    input wire logic counter_locked,
    input wire logic counter_armed,
    input wire logic epoch_monitor_out,
    input wire bsi_aux_s aux_byte
);
    logic [31:0] mon_cnt_ff;
    logic [31:0] nxt_mon_cnt;
    // width of the monitor pulse, too long for a repetition
    always_comb nxt_mon_cnt = epoch_monitor_out ? mon_cnt_ff + 32'h1 : '0;
    always_ff @(posedge ref_clk) mon_cnt_ff <= rstn ? nxt_mon_cnt : '0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sample_pulse_a: assert property (
        on_tick_sample.valid |=> !on_tick_sample.valid)
        else $error("long valid");
    tick_flag_a: assert property (
        on_tick_sample.on_tick |-> on_tick_sample.valid)
        else $error("bad tick");
    stream_mask_a: assert property (
        on_tick_sample.valid
        |-> (on_tick_sample.bits & ~$past(stream_active)) == '0)
        else $error("masked stream seen");
    set_value_a: assert property (
        $rose(counter_locked) |-> observe_time_counter == $past(set_seconds))
        else $error("wrong set value");
    arm_on_cmd_a: assert property (
        set_cmd && !counter_locked && !counter_reset |=> counter_armed)
        else $error("not armed");
    set_refused_a: assert property (
        set_cmd && counter_locked |=> !counter_armed)
        else $error("rearmed");
    clear_all_a: assert property (
        counter_reset |=> !counter_locked && !counter_armed
        && observe_time_counter == '0) else $error("not cleared");
    count_step_a: assert property (
        counter_locked && $past(counter_locked)
        && $changed(observe_time_counter)
        |-> observe_time_counter == $past(observe_time_counter) + 32'h1)
        else $error("counter jumped");
    mon_start_a: assert property (
        $rose(counter_locked) |=> epoch_monitor_out)
        else $error("no monitor");
    mon_width_a: assert property (
        $fell(epoch_monitor_out) |-> mon_cnt_ff == MON_PULSE_CYCLES)
        else $error("monitor width");
    aux_pulse_a: assert property (
        aux_byte.valid |=> !aux_byte.valid) else $error("long aux valid");
    cover property (on_tick_sample.on_tick);
    cover property ($rose(counter_locked));
    cover property (aux_byte.valid && aux_byte.frame_err);
endmodule // bsi_sampler_checker
bind bsi_sampler bsi_sampler_checker #(.MON_PULSE_CYCLES(MON_PULSE_CYCLES))
    bsi_sampler_checker_i (.ref_clk(ref_clk), .rstn(rstn),
    .stream_active(stream_active), .set_cmd(set_cmd),
    .set_seconds(set_seconds), .counter_reset(counter_reset),
    .on_tick_sample(on_tick_sample),
    .observe_time_counter(observe_time_counter),
    .counter_locked(counter_locked), .counter_armed(counter_armed),
    .epoch_monitor_out(epoch_monitor_out), .aux_byte(aux_byte));
`default_nettype wire

/* tb/bsi_sampler_tb.sv */
// self-checking bench for the bit-stream input sampler
// assumes the far-side model drives every pin input
`timescale 1ns/1ns
`default_nettype none
module bsi_sampler_tb
    import bsi_pkg::*;
;
    logic ref_clk, rstn, sample_clock, second_tick, alternate_second_tick;
    logic aux_serial_in, use_alt_tick, set_cmd, counter_reset;
    logic counter_locked, counter_armed, epoch_monitor_out;
    logic [31:0] input_bit_stream, stream_active, set_seconds;
    logic [31:0] observe_time_counter;
    logic [2:0] freq_sel, rate_k;
    bsi_sample_s on_tick_sample;
    bsi_aux_s aux_byte;
    int miscompares = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    // short second (20 << 2 sample clocks) keeps the run small
    bsi_sampler #(.BASE_CYCLES_PER_SEC(20), .MON_PULSE_CYCLES(8))
    bsi_sampler_i (
        .ref_clk(ref_clk), .rstn(rstn), .sample_clock(sample_clock),
        .second_tick(second_tick),
        .alternate_second_tick(alternate_second_tick),
        .input_bit_stream(input_bit_stream), .aux_serial_in(aux_serial_in),
        .freq_sel(freq_sel), .rate_k(rate_k), .stream_active(stream_active),
        .use_alt_tick(use_alt_tick), .set_cmd(set_cmd),
        .set_seconds(set_seconds), .counter_reset(counter_reset),
        .on_tick_sample(on_tick_sample),
        .observe_time_counter(observe_time_counter),
        .counter_locked(counter_locked), .counter_armed(counter_armed),
        .epoch_monitor_out(epoch_monitor_out), .aux_byte(aux_byte));
    bsi_far_model #(.PER_SEC(80)) bsi_far_model_i (
        .sample_clock(sample_clock), .second_tick(second_tick),
        .alternate_second_tick(alternate_second_tick),
        .input_bit_stream(input_bit_stream), .aux_serial_in(aux_serial_in));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // a hang counts as a mismatch; the run needs about 33500 cycles
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // let the edge's updates land before looking
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(input bit clr);
        @(posedge ref_clk) begin
            if (clr) counter_reset <= 1'b1;
            else set_cmd <= 1'b1;
        end
        @(posedge ref_clk) {counter_reset, set_cmd} <= 2'b00;
    endtask
    task automatic t_reset(input int n);
        @(posedge ref_clk) rstn <= 1'b0;
        repeat (n) @(posedge ref_clk);
        rstn <= 1'b1;
        step();
        check("counter", observe_time_counter, 32'h0);
        check("locked", 32'(counter_locked), 32'h0);
        $display("reset test done");
    endtask
    // on-tick bits, then the sample 2^k clocks on, under four masks;
    // k=3 is above the 8 MHz setting, so it must act as k=2
    task automatic t_sample();
        logic [31:0] m [4] = '{32'h0000ffff, 32'hffff0000, 32'h000000ff,
                               32'h0000000f};
        int n;
        for (int k = 0; k < 4; k++) begin
            n = (k > 2) ? 4 : (1 << k);
            @(posedge ref_clk) begin
                rate_k <= 3'(k);
                stream_active <= m[k];
            end
            step();
            while (on_tick_sample.on_tick !== 1'b1) step();
            check("tick bits", on_tick_sample.bits, 32'h0000ffff & m[k]);
            step();
            while (on_tick_sample.valid !== 1'b1) step();
            check("next bits", on_tick_sample.bits,
                  {16'(n), ~16'(n)} & m[k]);
        end
        $display("sample test done");
    endtask
    task automatic t_counter();
        @(posedge ref_clk) set_seconds <= 32'h00001234;
        pulse(1'b0);
        while (counter_locked !== 1'b1) step();
        check("set", observe_time_counter, 32'h00001234);
        while (observe_time_counter === 32'h00001234) step();
        check("step", observe_time_counter, 32'h00001235);
        @(posedge ref_clk) set_seconds <= 32'h00000005;
        pulse(1'b0);
        step();
        check("armed", 32'(counter_armed), 32'h0);
        repeat (700) step();
        check("ignored", observe_time_counter, 32'h00001236);
        pulse(1'b1);
        step();
        check("cleared", observe_time_counter, 32'h0);
        @(posedge ref_clk) begin
            use_alt_tick <= 1'b1;
            set_seconds <= 32'h00000077;
        end
        pulse(1'b0);
        #1234;
        bsi_far_model_i.alt_pulse();
        while (counter_locked !== 1'b1) step();
        check("alt set", observe_time_counter, 32'h00000077);
        $display("counter test done");
    endtask
    task automatic t_aux(input logic [7:0] b, input logic stp);
        fork
            bsi_far_model_i.send(b, stp);
            begin
                step();
                while (aux_byte.valid !== 1'b1) step();
                check("aux data", 32'(aux_byte.data), 32'(b));
                check("aux ferr", 32'(aux_byte.frame_err), 32'(!stp));
            end
        join
        $display("aux test done");
    endtask
    initial begin
        rstn = 1'b0;
        freq_sel = 3'h2;
        rate_k = 3'h0;
        stream_active = '0;
        use_alt_tick = 1'b0;
        set_cmd = 1'b0;
        set_seconds = '0;
        counter_reset = 1'b0;
        t_reset(10);
        t_sample();
        t_counter();
        t_reset(3);
        t_aux(8'ha5, 1'b1);
        t_aux(8'h3c, 1'b1);
        t_aux(8'h81, 1'b0);
        end_sim();
    end
endmodule // bsi_sampler_tb
`default_nettype wire
